// ---- hdl/timer_pair_params.svh ----
// Register indices, field positions, reset values and bus codes of the timer pair
`ifndef TIMER_PAIR_PARAMS_SVH
`define TIMER_PAIR_PARAMS_SVH

`define IDX_PORT_B_OUTPUT 4'h0
`define IDX_PORT_B_DIRECTION 4'h2
`define IDX_T1_LOW_COUNT 4'h4
`define IDX_T1_HIGH_COUNT 4'h5
`define IDX_T1_LOW_RELOAD 4'h6
`define IDX_T1_HIGH_RELOAD 4'h7
`define IDX_T2_LOW_COUNT 4'h8
`define IDX_T2_HIGH_COUNT 4'h9
`define IDX_AUX_CONTROL 4'hB
`define IDX_INT_FLAG 4'hD
`define IDX_INT_ENABLE 4'hE

`define AUX_T2_PULSE_BIT 5
`define AUX_T1_FREE_RUN_BIT 6
`define AUX_T1_PB7_BIT 7
`define FLAG_T2_BIT 5
`define FLAG_T1_BIT 6
`define FLAG_ANY_BIT 7
`define IER_SET_BIT 7
`define PB_LINE_SEVEN_BIT 7

`define RESET_BYTE 8'h00
`define RESET_COUNT 16'h0000
`define COUNT_ZERO 16'h0000
`define COUNT_STEP 16'h0001
`define PIN_IDLE_LEVEL 1'b1

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- hdl/timer_pair_pkg.sv ----
// State types of the dual interval timer pair
package timer_pair_pkg;

  typedef struct packed {
    logic [15:0] count;
  } counter_state_s;

  typedef struct packed {
    logic stage1;
    logic stage2;
  } sync_state_s;

  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [5:0] waddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [7:0] timer_one_low_reload;
    logic [7:0] timer_one_high_reload;
    logic [7:0] timer_two_low_reload;
    logic t1_armed;
    logic t2_armed;
    logic t1_flag;
    logic t2_flag;
    logic pb7_timer;
    logic pb7_out;
    logic irq_b;
    logic pb6_prev;
    logic [7:0] auxiliary_control;
    logic [7:0] int_enable;
    logic [7:0] port_b_output_latch;
    logic [7:0] port_b_direction;
  } main_state_s;

endpackage : timer_pair_pkg

// ---- hdl/pin_sync2.sv ----
// Two flip-flop synchroniser for a pin level
`timescale 1ns/1ns
`include "timer_pair_params.svh"
module pin_sync2
  import timer_pair_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic async_i,
  output logic sync_o
);
  sync_state_s state;
  sync_state_s next_state;

  always_comb begin
    next_state.stage1 = async_i;
    next_state.stage2 = state.stage1;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      state <= {`PIN_IDLE_LEVEL, `PIN_IDLE_LEVEL};
    end else begin
      state <= next_state;
    end
  end

  assign sync_o = state.stage2;
endmodule : pin_sync2

// ---- hdl/down_counter16.sv ----
// Sixteen-bit down counter with load, reload at zero and wrap
`timescale 1ns/1ns
`include "timer_pair_params.svh"
module down_counter16
  import timer_pair_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic load_i,
  input wire logic [15:0] load_value_i,
  input wire logic reload_at_zero_i,
  input wire logic [15:0] reload_value_i,
  input wire logic decrement_i,
  output logic [15:0] count_o,
  output logic zero_event_o
);
  counter_state_s state;
  counter_state_s next_state;

  always_comb begin
    zero_event_o = decrement_i && !load_i && (state.count == `COUNT_ZERO);
    next_state = state;
    if (load_i) begin
      next_state.count = load_value_i;
    end else if (zero_event_o && reload_at_zero_i) begin
      next_state.count = reload_value_i;
    end else if (decrement_i) begin
      // Wraps from zero to all ones
      next_state.count = state.count - `COUNT_STEP;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      state.count <= `RESET_COUNT;
    end else begin
      state <= next_state;
    end
  end

  assign count_o = state.count;
endmodule : down_counter16

// ---- hdl/dual_interval_timer_pair.sv ----
// Two interval timers with AXI4-Lite register access
// Overview of operation
// [R1] Software clears aux bits 6 and 7 for interrupt-only one-shot.
// [R2] Timer-one low count write stores low latch only; counter untouched.
// [R3] Timer-one high count write: latch, load counter, start, clear flag.
// [R4] Timer one decrements from the next clock, once every clock.
// [R5] One-shot: timer-one flag set once at zero per high load.
// [R6] One-shot with aux bit 7: line seven low at load, high at zero.
// [R7] Timer-one low count read returns counter low, clears flag bit 6.
// [R8] Writing one to flag bit 6 clears the timer-one flag.
// [R9] Free-run: at zero set flag, toggle line seven, reload, continue.
// [R10] Every high count write restarts the full time-out.
// [R11] Latch writes alone never disturb a running countdown.
// [R12] Low reload writes like low count; its read leaves the flag.
// [R13] High reload write stores latch, clears flag, no transfer.
// [R14] Timer-one high count read returns counter high byte only.
// [R15] Line seven is timer output only if direction and aux bit 7 set.
// [R16] One aux bit picks timer two interval or line-six pulse count.
// [R17] Timer two: low latch, low count, high count; decrements each clock.
// [R18] Timer two one-shot: flag at zero, wrap to all ones, continue.
// [R19] Timer two flags only once until its high count is rewritten.
// [R20] Timer-two flag clears on low count read or high count write.
// [R21] An enabled set flag drives the interrupt request low.
// [R22] Timer-two high write also loads low latch into low counter.
// [R23] Aux bit 6 selects timer-one one-shot or free-run reload.
// [R24] Timer-one one-shot wraps through zero without further flags.
`timescale 1ns/1ns
`include "timer_pair_params.svh"
module dual_interval_timer_pair
  import timer_pair_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic [5:0] s_axil_awaddr_i,
  input wire logic s_axil_awvalid_i,
  output logic s_axil_awready_o,
  input wire logic [31:0] s_axil_wdata_i,
  input wire logic [3:0] s_axil_wstrb_i,
  input wire logic s_axil_wvalid_i,
  output logic s_axil_wready_o,
  output logic [1:0] s_axil_bresp_o,
  output logic s_axil_bvalid_o,
  input wire logic s_axil_bready_i,
  input wire logic [5:0] s_axil_araddr_i,
  input wire logic s_axil_arvalid_i,
  output logic s_axil_arready_o,
  output logic [31:0] s_axil_rdata_o,
  output logic [1:0] s_axil_rresp_o,
  output logic s_axil_rvalid_o,
  input wire logic s_axil_rready_i,
  input wire logic port_b_line_six_i,
  output logic port_b_line_seven_o,
  output logic port_b_line_seven_oe_o,
  output logic irq_b_o
);
  main_state_s state;
  main_state_s next_state;

  logic aw_take;
  logic w_take;
  logic wr_go;
  logic wr_en;
  logic [3:0] wr_idx;
  logic ar_take;
  logic rd_en;
  logic [3:0] rd_idx;
  logic [7:0] rd_byte;
  logic t1_free_run;
  logic t1_load;
  logic t1_clear;
  logic t1_set;
  logic t2_load;
  logic t2_clear;
  logic t2_set;
  logic t2_decrement;
  logic pb6_sync;
  logic pb6_fall;
  logic flag_any;
  logic [15:0] t1_count;
  logic t1_zero;
  logic [15:0] t2_count;
  logic t2_zero;

  function automatic logic is_mapped(input logic [5:0] addr);
    logic [3:0] idx;
    idx = addr[5:2];
    unique case (idx)
      `IDX_PORT_B_OUTPUT, `IDX_PORT_B_DIRECTION,
      `IDX_T1_LOW_COUNT, `IDX_T1_HIGH_COUNT,
      `IDX_T1_LOW_RELOAD, `IDX_T1_HIGH_RELOAD,
      `IDX_T2_LOW_COUNT, `IDX_T2_HIGH_COUNT,
      `IDX_AUX_CONTROL, `IDX_INT_FLAG, `IDX_INT_ENABLE: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  pin_sync2 u_pb6_sync (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .async_i(port_b_line_six_i),
    .sync_o(pb6_sync)
  );

  down_counter16 u_timer_one (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .load_i(t1_load),
    .load_value_i({state.wdata, state.timer_one_low_reload}),
    .reload_at_zero_i(t1_free_run),
    .reload_value_i({state.timer_one_high_reload,
                     state.timer_one_low_reload}),
    .decrement_i(1'b1),
    .count_o(t1_count),
    .zero_event_o(t1_zero)
  );

  down_counter16 u_timer_two (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .load_i(t2_load),
    .load_value_i({state.wdata, state.timer_two_low_reload}),
    .reload_at_zero_i(1'b0),
    .reload_value_i(`RESET_COUNT),
    .decrement_i(t2_decrement),
    .count_o(t2_count),
    .zero_event_o(t2_zero)
  );

  // Bus handshakes and decoded strobes
  always_comb begin
    s_axil_awready_o = !state.aw_got && !state.bvalid;
    s_axil_wready_o = !state.w_got && !state.bvalid;
    s_axil_arready_o = !state.rvalid;
    aw_take = s_axil_awvalid_i && s_axil_awready_o;
    w_take = s_axil_wvalid_i && s_axil_wready_o;
    wr_go = state.aw_got && state.w_got && !state.bvalid;
    wr_idx = state.waddr[5:2];
    wr_en = wr_go && is_mapped(state.waddr) && state.wstrb0;
    ar_take = s_axil_arvalid_i && s_axil_arready_o;
    rd_idx = s_axil_araddr_i[5:2];
    rd_en = ar_take && is_mapped(s_axil_araddr_i);
  end

  // Timer control terms
  always_comb begin
    t1_free_run = state.auxiliary_control[`AUX_T1_FREE_RUN_BIT]; // see [R23]
    pb6_fall = state.pb6_prev && !pb6_sync;
    t2_decrement = state.auxiliary_control[`AUX_T2_PULSE_BIT] ?
                   pb6_fall : 1'b1; // see [R16] see [R17]
    t1_load = wr_en && (wr_idx == `IDX_T1_HIGH_COUNT); // see [R3] see [R10]
    t2_load = wr_en && (wr_idx == `IDX_T2_HIGH_COUNT); // see [R22]
    t1_clear = (wr_en && (wr_idx == `IDX_T1_HIGH_COUNT)) ||
               (wr_en && (wr_idx == `IDX_T1_HIGH_RELOAD)) || // see [R13]
               (rd_en && (rd_idx == `IDX_T1_LOW_COUNT)) || // see [R7]
               (wr_en && (wr_idx == `IDX_INT_FLAG) &&
                state.wdata[`FLAG_T1_BIT]); // see [R8]
    t2_clear = t2_load ||
               (rd_en && (rd_idx == `IDX_T2_LOW_COUNT)) || // see [R20]
               (wr_en && (wr_idx == `IDX_INT_FLAG) &&
                state.wdata[`FLAG_T2_BIT]);
    t1_set = t1_zero && (t1_free_run || state.t1_armed); // see [R5] see [R9]
    t2_set = t2_zero && state.t2_armed; // see [R18] see [R19]
    flag_any = (state.t1_flag && state.int_enable[`FLAG_T1_BIT]) ||
               (state.t2_flag && state.int_enable[`FLAG_T2_BIT]);
  end

  // Read data selection
  always_comb begin
    rd_byte = `RESET_BYTE;
    unique case (rd_idx)
      `IDX_PORT_B_OUTPUT: rd_byte = state.port_b_output_latch;
      `IDX_PORT_B_DIRECTION: rd_byte = state.port_b_direction;
      `IDX_T1_LOW_COUNT: rd_byte = t1_count[7:0];
      `IDX_T1_HIGH_COUNT: rd_byte = t1_count[15:8]; // see [R14]
      `IDX_T1_LOW_RELOAD: rd_byte = state.timer_one_low_reload; // see [R12]
      `IDX_T1_HIGH_RELOAD: rd_byte = state.timer_one_high_reload;
      `IDX_T2_LOW_COUNT: rd_byte = t2_count[7:0];
      `IDX_T2_HIGH_COUNT: rd_byte = t2_count[15:8];
      `IDX_AUX_CONTROL: rd_byte = state.auxiliary_control;
      `IDX_INT_FLAG: begin
        rd_byte[`FLAG_ANY_BIT] = flag_any;
        rd_byte[`FLAG_T1_BIT] = state.t1_flag;
        rd_byte[`FLAG_T2_BIT] = state.t2_flag;
      end
      `IDX_INT_ENABLE: begin
        rd_byte = state.int_enable;
        rd_byte[`IER_SET_BIT] = 1'b1;
      end
      default: rd_byte = `RESET_BYTE;
    endcase
  end

  always_comb begin
    next_state = state;
    next_state.pb6_prev = pb6_sync;

    // Write channel capture, in either order
    if (aw_take) begin
      next_state.aw_got = 1'b1;
      next_state.waddr = s_axil_awaddr_i;
    end
    if (w_take) begin
      next_state.w_got = 1'b1;
      next_state.wdata = s_axil_wdata_i[7:0];
      next_state.wstrb0 = s_axil_wstrb_i[0];
    end
    if (wr_go) begin
      next_state.aw_got = 1'b0;
      next_state.w_got = 1'b0;
      next_state.bvalid = 1'b1;
      next_state.bresp = is_mapped(state.waddr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (state.bvalid && s_axil_bready_i) begin
      next_state.bvalid = 1'b0;
    end

    // Read channel
    if (ar_take) begin
      next_state.rvalid = 1'b1;
      next_state.rdata = rd_byte;
      next_state.rresp = rd_en ? `RESP_OKAY : `RESP_SLVERR;
    end else if (state.rvalid && s_axil_rready_i) begin
      next_state.rvalid = 1'b0;
    end

    // Register writes
    if (wr_en) begin
      unique case (wr_idx)
        `IDX_PORT_B_OUTPUT: next_state.port_b_output_latch = state.wdata;
        `IDX_PORT_B_DIRECTION: next_state.port_b_direction = state.wdata;
        `IDX_T1_LOW_COUNT, `IDX_T1_LOW_RELOAD:
          next_state.timer_one_low_reload = state.wdata; // see [R2] see [R11]
        `IDX_T1_HIGH_COUNT, `IDX_T1_HIGH_RELOAD:
          next_state.timer_one_high_reload = state.wdata; // see [R13]
        `IDX_T2_LOW_COUNT: next_state.timer_two_low_reload = state.wdata;
        `IDX_AUX_CONTROL: next_state.auxiliary_control = state.wdata;
        `IDX_INT_ENABLE: begin
          if (state.wdata[`IER_SET_BIT]) begin
            next_state.int_enable = state.int_enable | state.wdata;
          end else begin
            next_state.int_enable = state.int_enable & ~state.wdata;
          end
        end
        default: next_state.int_enable = state.int_enable;
      endcase
    end

    // Timer one arming, flag and line seven waveform
    if (t1_load) begin
      next_state.t1_armed = 1'b1; // see [R4] see [R10]
      next_state.pb7_timer = 1'b0; // see [R6]
    end else if (t1_zero && t1_free_run) begin
      next_state.pb7_timer = !state.pb7_timer; // see [R9]
    end else if (t1_zero && state.t1_armed) begin
      next_state.t1_armed = 1'b0; // see [R24]
      next_state.pb7_timer = 1'b1; // see [R6]
    end
    // A hardware set wins over a same-cycle clear
    next_state.t1_flag = t1_set || (state.t1_flag && !t1_clear);

    // Timer two arming and flag
    if (t2_load) begin
      next_state.t2_armed = 1'b1;
    end else if (t2_zero) begin
      next_state.t2_armed = 1'b0; // see [R19]
    end
    next_state.t2_flag = t2_set || (state.t2_flag && !t2_clear);

    // Pin and interrupt outputs are registered
    next_state.pb7_out =
      (state.port_b_direction[`PB_LINE_SEVEN_BIT] &&
       state.auxiliary_control[`AUX_T1_PB7_BIT]) ?
      state.pb7_timer : state.port_b_output_latch[`PB_LINE_SEVEN_BIT]; // see [R15]
    next_state.irq_b = !flag_any; // see [R21]
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      state.aw_got <= 1'b0;
      state.w_got <= 1'b0;
      state.waddr <= 6'h00;
      state.wdata <= `RESET_BYTE;
      state.wstrb0 <= 1'b0;
      state.bvalid <= 1'b0;
      state.bresp <= `RESP_OKAY;
      state.rvalid <= 1'b0;
      state.rdata <= `RESET_BYTE;
      state.rresp <= `RESP_OKAY;
      state.timer_one_low_reload <= `RESET_BYTE;
      state.timer_one_high_reload <= `RESET_BYTE;
      state.timer_two_low_reload <= `RESET_BYTE;
      state.t1_armed <= 1'b0;
      state.t2_armed <= 1'b0;
      state.t1_flag <= 1'b0;
      state.t2_flag <= 1'b0;
      state.pb7_timer <= 1'b1;
      state.pb7_out <= 1'b0;
      state.irq_b <= 1'b1;
      state.pb6_prev <= `PIN_IDLE_LEVEL;
      state.auxiliary_control <= `RESET_BYTE;
      state.int_enable <= `RESET_BYTE;
      state.port_b_output_latch <= `RESET_BYTE;
      state.port_b_direction <= `RESET_BYTE;
    end else begin
      state <= next_state;
    end
  end

  assign s_axil_bvalid_o = state.bvalid;
  assign s_axil_bresp_o = state.bresp;
  assign s_axil_rvalid_o = state.rvalid;
  assign s_axil_rresp_o = state.rresp;
  assign s_axil_rdata_o = {24'h00_0000, state.rdata};
  assign port_b_line_seven_o = state.pb7_out;
  assign port_b_line_seven_oe_o = state.port_b_direction[`PB_LINE_SEVEN_BIT];
  assign irq_b_o = state.irq_b;
endmodule : dual_interval_timer_pair

// ---- verification/timer_pair_chk.sv ----
// Bus handshake and reset assertions for the timer pair
`timescale 1ns/1ns
module timer_pair_chk (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic s_axil_awvalid_i,
  input wire logic s_axil_awready_o,
  input wire logic s_axil_wvalid_i,
  input wire logic s_axil_wready_o,
  input wire logic [1:0] s_axil_bresp_o,
  input wire logic s_axil_bvalid_o,
  input wire logic s_axil_bready_i,
  input wire logic [5:0] s_axil_araddr_i,
  input wire logic s_axil_arvalid_i,
  input wire logic s_axil_arready_o,
  input wire logic [31:0] s_axil_rdata_o,
  input wire logic [1:0] s_axil_rresp_o,
  input wire logic s_axil_rvalid_o,
  input wire logic s_axil_rready_i,
  input wire logic port_b_line_seven_oe_o,
  input wire logic irq_b_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  sequence s_wr_taken;
    s_axil_awvalid_i && s_axil_awready_o &&
    s_axil_wvalid_i && s_axil_wready_o;
  endsequence
  sequence s_rd_taken;
    s_axil_arvalid_i && s_axil_arready_o;
  endsequence
  a_wr_answer: assert property (disable iff (!rst_b_i)
    s_wr_taken |=> !s_axil_bvalid_o ##1 s_axil_bvalid_o)
    else $error("write answer not two cycles after acceptance");
  a_wr_refused: assert property (disable iff (!rst_b_i)
    s_axil_bvalid_o |-> !s_axil_awready_o && !s_axil_wready_o)
    else $error("write channel open while answer pending");
  a_b_holds: assert property (disable iff (!rst_b_i)
    s_axil_bvalid_o && !s_axil_bready_i |=> s_axil_bvalid_o
    && $stable(s_axil_bresp_o)) else $error("write answer dropped");
  a_r_holds: assert property (disable iff (!rst_b_i)
    s_axil_rvalid_o && !s_axil_rready_i |=> s_axil_rvalid_o
    && $stable(s_axil_rdata_o)) else $error("read answer dropped");
  a_rd_refused: assert property (disable iff (!rst_b_i)
    s_axil_rvalid_o |-> !s_axil_arready_o)
    else $error("read address open while answer pending");
  a_rd_answer: assert property (disable iff (!rst_b_i)
    s_rd_taken |=> s_axil_rvalid_o && s_axil_rdata_o[31:8] == '0)
    else $error("read answer late or upper bytes set");
  a_unmapped_err: assert property (disable iff (!rst_b_i)
    (s_rd_taken ##0 s_axil_araddr_i[5:2] == 4'hF) |=>
    s_axil_rresp_o == 2'h2) else $error("unmapped read not refused");
  a_reset_idle: assert property (!rst_b_i |=> irq_b_o &&
    !s_axil_bvalid_o && !s_axil_rvalid_o && !port_b_line_seven_oe_o)
    else $error("outputs not idle after reset");
endmodule : timer_pair_chk

bind dual_interval_timer_pair timer_pair_chk i_timer_pair_chk (.*);

// ---- verification/cpu_model.sv ----
// Register-bus master standing in for the processor
`timescale 1ns/1ns
module cpu_model (
  input wire logic clk_i,
  output logic [5:0] awaddr_o,
  output logic awvalid_o,
  input wire logic awready_i,
  output logic [31:0] wdata_o,
  output logic [3:0] wstrb_o,
  output logic wvalid_o,
  input wire logic wready_i,
  input wire logic [1:0] bresp_i,
  input wire logic bvalid_i,
  output logic bready_o,
  output logic [5:0] araddr_o,
  output logic arvalid_o,
  input wire logic arready_i,
  input wire logic [31:0] rdata_i,
  input wire logic [1:0] rresp_i,
  input wire logic rvalid_i,
  output logic rready_o
);
  // Ready rises once more than this many cycles have passed since the request
  int stall = 0;
  initial begin
    awaddr_o = 6'h00;
    wdata_o = 32'h0000_0000;
    wstrb_o = 4'h0;
    araddr_o = 6'h00;
    {awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} = 5'h00;
  end
  task automatic write(input logic [3:0] idx, input logic [7:0] d,
    output logic [1:0] rsp);
    int k;
    k = 0;
    awaddr_o <= {idx, 2'b00};
    wdata_o <= {24'h00_0000, d};
    wstrb_o <= 4'h1;
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
      // Released payload is scrambled, never left showing
      if (awvalid_o && awready_i) begin
        awvalid_o <= 1'b0;
        awaddr_o <= ~awaddr_o;
      end
      if (wvalid_o && wready_i) begin
        wvalid_o <= 1'b0;
        wdata_o <= ~wdata_o;
      end
      if (k > stall) bready_o <= 1'b1;
    end while (!(bvalid_i && bready_o));
    rsp = bresp_i;
    bready_o <= 1'b0;
  endtask : write
  task automatic read(input logic [3:0] idx, output logic [7:0] d,
    output logic [1:0] rsp);
    int k;
    k = 0;
    araddr_o <= {idx, 2'b00};
    arvalid_o <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
      if (arvalid_o && arready_i) begin
        arvalid_o <= 1'b0;
        araddr_o <= ~araddr_o;
      end
      if (k > stall) rready_o <= 1'b1;
    end while (!(rvalid_i && rready_o));
    d = rdata_i[7:0];
    rsp = rresp_i;
    rready_o <= 1'b0;
  endtask : read
endmodule : cpu_model

// ---- verification/tb_top.sv ----
// Self-checking bench for the dual interval timer pair
`timescale 1ns/1ns
`include "timer_pair_params.svh"
module tb_top;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic port_b_line_six_i = 1'b1;
  logic [5:0] s_axil_awaddr_i, s_axil_araddr_i;
  logic [31:0] s_axil_wdata_i, s_axil_rdata_o;
  logic [3:0] s_axil_wstrb_i;
  logic [1:0] s_axil_bresp_o, s_axil_rresp_o, rsp;
  logic s_axil_awvalid_i, s_axil_wvalid_i, s_axil_bready_i;
  logic s_axil_arvalid_i, s_axil_rready_i, s_axil_awready_o;
  logic s_axil_wready_o, s_axil_bvalid_o, s_axil_arready_o;
  logic s_axil_rvalid_o, port_b_line_seven_o, prev7;
  logic port_b_line_seven_oe_o, irq_b_o;
  logic [15:0] gap = 16'h0000;
  logic [7:0] rd;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  int last_t = 0;
  int n_tog = 0;
  int n;

  always #4 sys_clk_i = ~sys_clk_i;

  dual_interval_timer_pair i_dual_interval_timer_pair (.*);
  cpu_model i_cpu_model (
    .clk_i(sys_clk_i), .awaddr_o(s_axil_awaddr_i),
    .awvalid_o(s_axil_awvalid_i), .awready_i(s_axil_awready_o),
    .wdata_o(s_axil_wdata_i), .wstrb_o(s_axil_wstrb_i),
    .wvalid_o(s_axil_wvalid_i), .wready_i(s_axil_wready_o),
    .bresp_i(s_axil_bresp_o), .bvalid_i(s_axil_bvalid_o),
    .bready_o(s_axil_bready_i), .araddr_o(s_axil_araddr_i),
    .arvalid_o(s_axil_arvalid_i), .arready_i(s_axil_arready_o),
    .rdata_i(s_axil_rdata_o), .rresp_i(s_axil_rresp_o),
    .rvalid_i(s_axil_rvalid_o), .rready_o(s_axil_rready_i)
  );

  // Spacing between changes of line seven, in clock cycles
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    prev7 <= port_b_line_seven_o;
    if (port_b_line_seven_o !== prev7) begin
      gap <= 16'(cyc - last_t);
      last_t <= cyc;
      n_tog <= n_tog + 1;
    end
  end

  task automatic check(input string w, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", w, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    i_cpu_model.write(i, d, rsp);
  endtask : wr
  task automatic rdc(input string w, input logic [3:0] i, logic [7:0] e);
    i_cpu_model.read(i, rd, rsp);
    check(w, {8'h00, rd}, {8'h00, e});
  endtask : rdc
  task automatic wait_irq();
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (irq_b_o !== 1'b0 && n < 400);
  endtask : wait_irq
  task automatic wait_tog();
    int t;
    t = n_tog;
    for (int k = 0; k < 600 && n_tog == t; k++) @(posedge sys_clk_i);
  endtask : wait_tog

  task automatic t_reset();
    check("irq idle", 16'(irq_b_o), 16'h0001);
    rdc("aux", `IDX_AUX_CONTROL, 8'h00);
    rdc("flags", `IDX_INT_FLAG, 8'h00);
    i_cpu_model.stall = 3;
    rdc("unmapped", 4'hF, 8'h00);
    check("unmapped rresp", 16'(rsp), 16'(`RESP_SLVERR));
    wr(4'hF, 8'h55);
    check("unmapped bresp", 16'(rsp), 16'(`RESP_SLVERR));
    i_cpu_model.stall = 0;
    wr(`IDX_AUX_CONTROL, 8'h80);
    wr(`IDX_PORT_B_OUTPUT, 8'h80);
    repeat (2) @(posedge sys_clk_i);
    check("line7 latch", 16'(port_b_line_seven_o), 16'h0001);
    wr(`IDX_PORT_B_DIRECTION, 8'h80);
    $display("test reset done");
  endtask : t_reset

  task automatic t_oneshot();
    wr(`IDX_INT_ENABLE, 8'hC0);
    wr(`IDX_T1_LOW_COUNT, 8'h40);
    rdc("low reload", `IDX_T1_LOW_RELOAD, 8'h40);
    for (int m = 0; m < 3; m++) begin
      wr(`IDX_T1_HIGH_COUNT, 8'h00);
      repeat (2) @(posedge sys_clk_i);
      check("line7 low", 16'(port_b_line_seven_o), 16'h0000);
      wait_irq();
      check("t1 expiry", 16'(n >= 63 && n <= 65), 16'h0001);
      check("line7 high", 16'(port_b_line_seven_o), 16'h0001);
      rdc("t1 wrapped", `IDX_T1_HIGH_COUNT, 8'hFF);
      rdc("flag kept", `IDX_INT_FLAG, 8'hC0);
      case (m)
        0: i_cpu_model.read(`IDX_T1_LOW_COUNT, rd, rsp);
        1: wr(`IDX_INT_FLAG, 8'h40);
        default: wr(`IDX_T1_HIGH_RELOAD, 8'h00);
      endcase
      rdc("flag cleared", `IDX_INT_FLAG, 8'h00);
      repeat (20) @(posedge sys_clk_i);
      check("one flag", 16'(irq_b_o), 16'h0001);
    end
    repeat (8) begin
      wr(`IDX_T1_HIGH_COUNT, 8'h00);
      repeat (40) @(posedge sys_clk_i);
    end
    check("retrigger", 16'(irq_b_o), 16'h0001);
    $display("test one-shot done");
  endtask : t_oneshot

  task automatic t_freerun();
    wr(`IDX_AUX_CONTROL, 8'hC0);
    wr(`IDX_T1_LOW_COUNT, 8'h10);
    wr(`IDX_T1_HIGH_COUNT, 8'h00);
    repeat (3) wait_tog();
    check("period", gap, 16'h0011);
    wr(`IDX_T1_LOW_RELOAD, 8'h20);
    wr(`IDX_T1_HIGH_RELOAD, 8'h01);
    wait_tog();
    check("period kept", gap, 16'h0011);
    wait_tog();
    check("new period", gap, 16'h0121);
    $display("test free-run done");
  endtask : t_freerun

  task automatic t_timer_two();
    wr(`IDX_AUX_CONTROL, 8'h00);
    wr(`IDX_INT_ENABLE, 8'h40);
    wr(`IDX_INT_ENABLE, 8'hA0);
    // Long timer-one count clears its flag and keeps it quiet for the test
    wr(`IDX_T1_HIGH_COUNT, 8'hFF);
    wr(`IDX_T2_LOW_COUNT, 8'h20);
    wr(`IDX_T2_HIGH_COUNT, 8'h00);
    wait_irq();
    check("t2 expiry", 16'(n >= 33 && n <= 35), 16'h0001);
    rdc("t2 flag", `IDX_INT_FLAG, 8'hA0);
    rdc("t2 wrapped", `IDX_T2_HIGH_COUNT, 8'hFF);
    i_cpu_model.read(`IDX_T2_LOW_COUNT, rd, rsp);
    rdc("t2 cleared", `IDX_INT_FLAG, 8'h00);
    wr(`IDX_AUX_CONTROL, 8'h20);
    wr(`IDX_T2_LOW_COUNT, 8'h03);
    wr(`IDX_T2_HIGH_COUNT, 8'h00);
    for (int p = 1; p <= 4; p++) begin
      port_b_line_six_i <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      port_b_line_six_i <= 1'b1;
      repeat (8) @(posedge sys_clk_i);
      check("pulse count", 16'(irq_b_o), 16'(p < 4));
    end
    wr(`IDX_INT_ENABLE, 8'h20);
    repeat (2) @(posedge sys_clk_i);
    check("masked", 16'(irq_b_o), 16'h0001);
    $display("test timer two done");
  endtask : t_timer_two

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    @(posedge sys_clk_i);
    t_reset();
    t_oneshot();
    t_freerun();
    t_timer_two();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    error_cnt++;
    wrap_up();
  end
endmodule : tb_top
